// [fsr_regs.svh]
// command codes, field positions, reset values and timing constants
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH

// command codes
`define OP_WREN    8'h06
`define OP_WRDI    8'h04
`define OP_RDSR    8'h05
`define OP_RDFSR   8'h70
`define OP_RDNVCR  8'hb5
`define OP_RDVCR   8'h85
`define OP_WRSR    8'h01
`define OP_WRNVCR  8'hb1
`define OP_WRVCR   8'h81
`define OP_RSTEN   8'h66
`define OP_RSTMEM  8'h99
`define OP_RDID    8'h9f
`define OP_MIORDID 8'haf
`define OP_SFDP    8'h5a
`define OP_READ    8'h03
`define OP_FREAD   8'h0b
`define OP_DIOR    8'hbb
`define OP_QIOR    8'heb
`define OP_EN4B    8'hb7
`define OP_EX4B    8'he9

// frame geometry
`define OPC_BITS     6'h08
`define BYTE_BITS    6'h08
`define NVCR_BITS    6'h10
`define ADDR3_BITS   6'h18
`define ADDR4_BITS   6'h20
`define SFDP_DUMMY   4'h8
`define SFDP_AW      11
`define LANE_1       3'h1
`define LANE_2       3'h2
`define LANE_4       3'h4
`define PROTO_DUAL   2'h1
`define PROTO_QUAD   2'h2

// register fields and reset values
`define NVCR_RESET   16'h8000
`define NVCR_DUMMY   15:12
`define NVCR_PROTO   3:2
`define NVCR_ADDR4   0
`define VCR_DUMMY    7:4
`define VCR_PROTO    3:2
`define VCR_WRAP_RST 2'h3
`define SR_PROT      7:2
`define SRP_RESET    6'h00

// timing
`define CLK_MHZ      10
`define WR_TIME_US   20
`define RST_TIME_US  5
`define DIE_COUNT    2

`endif

// [fsr_pkg.sv]
// shared types of the serial flash front end
package fsr_pkg;

  // link-side frame phases
  typedef enum logic [2:0] {
    LS_OPC    = 3'h0,
    LS_ADDR   = 3'h1,
    LS_DUMMY  = 3'h2,
    LS_DOUT   = 3'h3,
    LS_DIN    = 3'h4,
    LS_IGNORE = 3'h5
  } fsr_lstate_e;

  // core state seen by the link side
  typedef struct packed {
    logic        addr4;
    logic        wel;
    logic        wbusy;
    logic        pe_busy;
    logic [1:0]  die_busy;
    logic [15:0] nvcr;
    logic [7:0]  vcr;
    logic [5:0]  srp;
  } fsr_cfg_s;

  // command handed from link to core
  typedef struct packed {
    logic [7:0]  op;
    logic [15:0] dat;
  } fsr_cmd_s;

endpackage

// [fsr_sync.sv]
// two-flop level synchroniser
`timescale 1ns/1ps
module fsr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // destination clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // level in, synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_ff; // first stage, read only by q

  // two stages, only the second looks at the first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end

endmodule

// [fsr_table.sv]
// discovery parameter table, loaded on clk, read on the link
`timescale 1ns/1ps
module fsr_table (
  // load port
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [10:0] wr_addr,
  input wire logic [7:0] wr_data,
  // link read port
  input wire logic [10:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [0:2047]; // one entry per table byte

  // load from the system side
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // asynchronous read, table is quasi-static
  assign rd_data = mem[rd_addr];

endmodule

// [fsr_top.sv]
// serial flash command front end: link decoder and core state
`timescale 1ns/1ps
`include "fsr_regs.svh"

module fsr_top
  import fsr_pkg::*;
#(
  parameter logic [31:0] ID_WORD = 32'h5a3c_1e0f // arbitrary identification value
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link pins
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic [3:0] serial_data_lines_in,
  output logic [3:0] serial_data_lines_out,
  output logic [3:0] serial_data_lines_oe_n,
  // memory array read, link clock domain
  output logic [31:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  // program and erase engine, core clock domain
  input wire logic pe_busy,
  input wire logic pe_suspended,
  output logic pe_abort,
  // discovery table load
  input wire logic tbl_wr_en,
  input wire logic [10:0] tbl_wr_addr,
  input wire logic [7:0] tbl_wr_data,
  // core status
  output logic addr4_mode,
  output logic [3:0] dummy_cycles
);

  localparam int WR_CYC = `WR_TIME_US * `CLK_MHZ; // per-die register write
  localparam int RST_CYC = `RST_TIME_US * `CLK_MHZ; // reset recovery
  localparam logic [15:0] WR_ALL = 16'(WR_CYC * `DIE_COUNT);
  localparam logic [15:0] NV_RST = `NVCR_RESET; // power-on nonvolatile image, indexable

  // lanes from protocol code
  function automatic logic [2:0] lanes_of(input logic [1:0] pr);
    if (pr == `PROTO_DUAL) return `LANE_2;
    else if (pr == `PROTO_QUAD) return `LANE_4;
    else return `LANE_1;
  endfunction

  // address and data lanes of a command
  function automatic logic [2:0] io_lanes(input logic [7:0] op, input logic [2:0] pl);
    if (op == `OP_QIOR) return `LANE_4;
    else if (op == `OP_DIOR && pl == `LANE_1) return `LANE_2;
    else return pl;
  endfunction

  // shift sampled lanes into the low end
  function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [3:0] d,
                                           input logic [2:0] n);
    if (n == `LANE_1) return {sh[30:0], d[0]};
    else if (n == `LANE_2) return {sh[29:0], d[1:0]};
    else return {sh[27:0], d};
  endfunction

  // vcr value derived from nonvolatile settings
  function automatic logic [7:0] vcr_from_nv(input logic [15:0] nv);
    return {nv[`NVCR_DUMMY], nv[`NVCR_PROTO], `VCR_WRAP_RST};
  endfunction

  // ---------------- crossings ----------------
  fsr_cfg_s cfg_c; // core state, clk domain
  fsr_cfg_s cfg_s; // same, on sclk
  fsr_cmd_s cmd_ff; // committed command, sclk, stable until next commit
  logic ev_tgl_ff; // toggles once per committed command
  logic [1:0] ev_s; // {select high, toggle} on clk

  fsr_sync #(.W($bits(fsr_cfg_s)), .RST_VAL('0)) u_cfg_sync (
    .clk(sclk), .rst_n(rst_n), .d(cfg_c), .q(cfg_s));
  fsr_sync #(.W(2), .RST_VAL(2'h2)) u_ev_sync (
    .clk(clk), .rst_n(rst_n), .d({chip_select_n, ev_tgl_ff}), .q(ev_s));

  // ---------------- link side ----------------
  fsr_lstate_e lst_ff, nxt_lst;
  logic [5:0] bcnt_ff; // bits taken in current phase
  logic [31:0] sh_ff; // incoming shift register
  logic [7:0] opc_ff; // decoded opcode
  logic [31:0] addr_ff; // running byte address
  logic [3:0] dcnt_ff; // dummy clocks taken
  logic [7:0] obyte_ff; // byte being shifted out
  logic [2:0] obit_ff; // bits of obyte already sent
  logic die_ff, fdie_ff; // polled die pointer, latched per frame
  logic rst_arm_ff; // reset enable accepted
  logic [2:0] ph_lanes, p_lanes;
  logic [31:0] sh_nx, rd_addr_c;
  logic [5:0] bit_nx, abits_c;
  logic [7:0] op_c, src_c, tbl_rd;
  logic [3:0] dtgt_c;
  logic load_c, cmt_c, simple_c, die_c;

  fsr_table u_table (
    .clk(clk), .wr_en(tbl_wr_en), .wr_addr(tbl_wr_addr), .wr_data(tbl_wr_data),
    .rd_addr(rd_addr_c[`SFDP_AW-1:0]), .rd_data(tbl_rd));

  // phase lanes and next shift value
  always_comb begin
    p_lanes = lanes_of(cfg_s.vcr[`VCR_PROTO]);
    op_c = (lst_ff == LS_OPC) ? 8'(shift_in(sh_ff, serial_data_lines_in, p_lanes)) : opc_ff;
    ph_lanes = (lst_ff == LS_OPC) ? p_lanes : io_lanes(opc_ff, p_lanes);
    sh_nx = shift_in(sh_ff, serial_data_lines_in, ph_lanes);
    bit_nx = bcnt_ff + 6'(ph_lanes);
    rd_addr_c = (lst_ff == LS_ADDR) ? sh_nx : addr_ff;
    die_c = (lst_ff == LS_OPC) ? die_ff : fdie_ff;
  end

  // address length and dummy target
  always_comb begin
    // four bytes only in four-byte mode; table always three
    abits_c = (opc_ff != `OP_SFDP && cfg_s.addr4) ? `ADDR4_BITS : `ADDR3_BITS;
    // table eight dummies, plain read none; others from volatile config
    if (opc_ff == `OP_SFDP) dtgt_c = `SFDP_DUMMY;
    else if (opc_ff == `OP_READ) dtgt_c = 4'h0;
    else dtgt_c = cfg_s.vcr[`VCR_DUMMY];
  end

  // source of the next output byte
  always_comb begin
    case (op_c)
      // status and flag of the polled die
      `OP_RDSR: src_c = {cfg_s.srp, cfg_s.wel, cfg_s.die_busy[die_c]};
      // flag bit 7 high once that die is idle
      `OP_RDFSR: src_c = {~cfg_s.die_busy[die_c], 6'h00, cfg_s.addr4};
      `OP_RDNVCR: src_c = rd_addr_c[0] ? cfg_s.nvcr[15:8] : cfg_s.nvcr[7:0];
      `OP_RDVCR: src_c = cfg_s.vcr;
      `OP_RDID, `OP_MIORDID: src_c = ID_WORD[8'(rd_addr_c[1:0]) * 8 +: 8];
      // eleven address bits wrap at 2048; wrap bits unused
      `OP_SFDP: src_c = tbl_rd;
      default: src_c = mem_rdata;
    endcase
  end

  // phase sequencing
  always_comb begin
    nxt_lst = lst_ff;
    load_c = 1'b0;
    simple_c = 1'b0;
    case (lst_ff)
      LS_OPC: begin
        if (bit_nx == `OPC_BITS) begin
          case (op_c)
            `OP_WREN, `OP_WRDI, `OP_EN4B, `OP_EX4B, `OP_RSTEN, `OP_RSTMEM: begin
              simple_c = 1'b1;
              nxt_lst = LS_IGNORE;
            end
            `OP_RDSR, `OP_RDFSR, `OP_RDNVCR, `OP_RDVCR: begin
              nxt_lst = LS_DOUT;
              load_c = 1'b1;
            end
            // id read dropped while program or erase runs
            `OP_RDID, `OP_MIORDID: begin
              nxt_lst = cfg_s.pe_busy ? LS_IGNORE : LS_DOUT;
              load_c = !cfg_s.pe_busy;
            end
            `OP_SFDP, `OP_READ, `OP_FREAD, `OP_DIOR, `OP_QIOR: nxt_lst = LS_ADDR;
            `OP_WRSR, `OP_WRNVCR, `OP_WRVCR: nxt_lst = LS_DIN;
            default: nxt_lst = LS_IGNORE;
          endcase
        end
      end
      LS_ADDR: begin
        if (bit_nx == abits_c) begin
          nxt_lst = (dtgt_c == 4'h0) ? LS_DOUT : LS_DUMMY;
          load_c = (dtgt_c == 4'h0);
        end
      end
      LS_DUMMY: begin
        if (dcnt_ff + 4'h1 == dtgt_c) begin
          nxt_lst = LS_DOUT;
          load_c = 1'b1;
        end
      end
      LS_DOUT: load_c = ({1'b0, obit_ff} + {1'b0, ph_lanes}) == 4'h8;
      default: nxt_lst = lst_ff;
    endcase
  end

  // frame state, cleared whenever select is high
  // raising select ends any read, back to standby
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      lst_ff <= LS_OPC;
      bcnt_ff <= 6'h00;
      sh_ff <= 32'h0000_0000;
      opc_ff <= 8'h00;
      addr_ff <= 32'h0000_0000;
      dcnt_ff <= 4'h0;
      obyte_ff <= 8'h00;
      obit_ff <= 3'h0;
      fdie_ff <= 1'b0;
    end else begin
      lst_ff <= nxt_lst;
      bcnt_ff <= (nxt_lst != lst_ff) ? 6'h00 : bit_nx;
      sh_ff <= (nxt_lst != lst_ff) ? 32'h0000_0000 : sh_nx;
      if (lst_ff == LS_OPC) opc_ff <= op_c;
      if (lst_ff == LS_OPC) fdie_ff <= die_ff;
      if (lst_ff == LS_ADDR) addr_ff <= sh_nx;
      if (lst_ff == LS_DUMMY) dcnt_ff <= dcnt_ff + 4'h1;
      if (lst_ff == LS_DOUT) obit_ff <= obit_ff + ph_lanes;
      // next byte loaded, address steps by one
      // counter runs on across the die boundary
      if (load_c) begin
        obyte_ff <= src_c;
        obit_ff <= 3'h0;
        addr_ff <= rd_addr_c + 32'h1;
      end
    end
  end

  // drive on the falling edge, msb first
  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      serial_data_lines_out <= 4'h0;
      serial_data_lines_oe_n <= 4'hf;
    end else if (lst_ff == LS_DOUT) begin
      // top bits of the byte go first
      if (ph_lanes == `LANE_1) begin
        serial_data_lines_out <= {2'h0, obyte_ff[3'h7 - obit_ff], 1'b0};
        serial_data_lines_oe_n <= 4'hd;
      end else if (ph_lanes == `LANE_2) begin
        serial_data_lines_out <= {2'h0, obyte_ff[3'h7 - obit_ff -: 2]};
        serial_data_lines_oe_n <= 4'hc;
      end else begin
        serial_data_lines_out <= obyte_ff[3'h7 - obit_ff -: 4];
        serial_data_lines_oe_n <= 4'h0;
      end
    end
  end

  assign mem_addr = rd_addr_c;

  // commit condition: simple command except reset enable, memory reset only when armed, or data bytes complete
  assign cmt_c = (lst_ff == LS_OPC && simple_c && op_c != `OP_RSTEN &&
                  (op_c != `OP_RSTMEM || rst_arm_ff)) ||
                 (lst_ff == LS_DIN && bit_nx == ((opc_ff == `OP_WRNVCR) ?
                  `NVCR_BITS : `BYTE_BITS));

  // command hand-over and reset arming, survive select
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_ff <= '0;
      ev_tgl_ff <= 1'b0;
      rst_arm_ff <= 1'b0;
      die_ff <= 1'b0;
    end else if (!chip_select_n) begin
      if (cmt_c) begin
        cmd_ff.op <= op_c;
        cmd_ff.dat <= sh_nx[15:0];
        ev_tgl_ff <= ~ev_tgl_ff;
      end
      // enable arms, memory reset fires; no arming while writing
      if (lst_ff == LS_OPC && bit_nx == `OPC_BITS) begin
        rst_arm_ff <= (op_c == `OP_RSTEN) && !cfg_s.wbusy;
        if (op_c == `OP_RDSR || op_c == `OP_RDFSR) die_ff <= ~die_ff;
      end
    end
  end

  // ---------------- core side ----------------
  logic seen_ff; // last toggle handled
  logic wel_ff; // write enable latch
  logic [5:0] srp_ff; // status protection bits
  logic [15:0] nvcr_ff; // nonvolatile config
  logic [7:0] vcr_ff; // volatile config
  logic addr4_ff; // four-byte address mode
  logic [15:0] wcnt_ff; // register write timer, both dies
  logic [15:0] rcnt_ff; // reset recovery timer
  logic pe_abort_ff;
  logic ev_c, sw_rst_c, wr_ok_c;

  // new command once select is high again
  assign ev_c = ev_s[1] && (ev_s[0] != seen_ff) && (rcnt_ff == 16'h0000);
  assign sw_rst_c = ev_c && cmd_ff.op == `OP_RSTMEM;
  assign wr_ok_c = ev_c && wel_ff;

  // event bookkeeping
  always_ff @(posedge clk) begin
    if (!rst_n) seen_ff <= 1'b0;
    else if (ev_s[1]) seen_ff <= ev_s[0];
  end

  // configuration registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nvcr_ff <= `NVCR_RESET;
      vcr_ff <= vcr_from_nv(`NVCR_RESET);
      addr4_ff <= NV_RST[`NVCR_ADDR4];
      srp_ff <= `SRP_RESET;
    // volatile settings back to nonvolatile defaults
    end else if (sw_rst_c) begin
      vcr_ff <= vcr_from_nv(nvcr_ff);
      addr4_ff <= nvcr_ff[`NVCR_ADDR4];
    end else if (ev_c) begin
      if (cmd_ff.op == `OP_EN4B) addr4_ff <= 1'b1;
      if (cmd_ff.op == `OP_EX4B) addr4_ff <= 1'b0;
      if (wr_ok_c && cmd_ff.op == `OP_WRSR) srp_ff <= cmd_ff.dat[`SR_PROT];
      if (wr_ok_c && cmd_ff.op == `OP_WRNVCR) nvcr_ff <= {cmd_ff.dat[7:0], cmd_ff.dat[15:8]};
      // dummy count changed through volatile config
      if (wr_ok_c && cmd_ff.op == `OP_WRVCR) vcr_ff <= cmd_ff.dat[7:0];
    end
  end

  // write enable latch
  always_ff @(posedge clk) begin
    if (!rst_n || sw_rst_c) wel_ff <= 1'b0;
    else if (ev_c && cmd_ff.op == `OP_WREN) wel_ff <= 1'b1;
    else if (ev_c && (cmd_ff.op == `OP_WRDI || cmd_ff.op == `OP_WRSR ||
             cmd_ff.op == `OP_WRNVCR || cmd_ff.op == `OP_WRVCR)) wel_ff <= 1'b0;
  end

  // timers and abort
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wcnt_ff <= 16'h0000;
      rcnt_ff <= 16'h0000;
      pe_abort_ff <= 1'b0;
    end else begin
      pe_abort_ff <= sw_rst_c && (pe_busy || pe_suspended);
      if (sw_rst_c) rcnt_ff <= 16'(RST_CYC);
      else if (rcnt_ff != 16'h0000) rcnt_ff <= rcnt_ff - 16'h1;
      if (sw_rst_c) wcnt_ff <= 16'h0000;
      else if (wr_ok_c && (cmd_ff.op == `OP_WRSR || cmd_ff.op == `OP_WRNVCR))
        wcnt_ff <= WR_ALL;
      else if (wcnt_ff != 16'h0000) wcnt_ff <= wcnt_ff - 16'h1;
    end
  end

  // state for the link; die 0 finishes before die 1; busy during recovery
  always_comb begin
    cfg_c.addr4 = addr4_ff;
    cfg_c.wel = wel_ff;
    cfg_c.wbusy = wcnt_ff != 16'h0000;
    cfg_c.pe_busy = pe_busy;
    cfg_c.die_busy[0] = pe_busy || rcnt_ff != 16'h0000 || wcnt_ff > 16'(WR_CYC);
    cfg_c.die_busy[1] = pe_busy || rcnt_ff != 16'h0000 || wcnt_ff != 16'h0000;
    cfg_c.nvcr = nvcr_ff;
    cfg_c.vcr = vcr_ff;
    cfg_c.srp = srp_ff;
  end

  assign pe_abort = pe_abort_ff;
  assign addr4_mode = addr4_ff;
  assign dummy_cycles = vcr_ff[`VCR_DUMMY];

  // ---------------- checks ----------------
  sequence s_opc_end;
    lst_ff == LS_OPC && bit_nx == `OPC_BITS;
  endsequence

  AST_OPC_LANES: assert property (@(posedge sclk) disable iff (chip_select_n)
    lst_ff == LS_OPC && bit_nx != `OPC_BITS |=> bcnt_ff == $past(bcnt_ff) + 6'(p_lanes))
    else $error("opcode bits not counted by protocol lanes");
  AST_QIO_LANES: assert property (@(posedge sclk) disable iff (chip_select_n)
    lst_ff == LS_ADDR && opc_ff == `OP_QIOR |-> ph_lanes == `LANE_4)
    else $error("quad io address not on four lanes");
  AST_ADDR_LEN: assert property (@(posedge sclk) disable iff (chip_select_n)
    lst_ff == LS_ADDR && nxt_lst != LS_ADDR && opc_ff != `OP_SFDP
    |-> bit_nx == (cfg_s.addr4 ? `ADDR4_BITS : `ADDR3_BITS))
    else $error("address length does not follow address mode");
  AST_SFDP_SEQ: assert property (@(posedge sclk) disable iff (chip_select_n)
    lst_ff == LS_ADDR && opc_ff == `OP_SFDP && bit_nx == `ADDR3_BITS
    |=> (lst_ff == LS_DUMMY) [*8] ##1 lst_ff == LS_DOUT)
    else $error("table read not three bytes then eight dummies");
  AST_SFDP_WRAP: assert property (@(posedge sclk) disable iff (chip_select_n)
    load_c && opc_ff == `OP_SFDP && lst_ff == LS_DOUT && addr_ff[10:0] == 11'h7ff
    |=> u_table.rd_addr == 11'h000)
    else $error("table address did not wrap to zero");
  AST_ID_BLOCK: assert property (@(posedge sclk) disable iff (chip_select_n)
    s_opc_end and (op_c == `OP_RDID && cfg_s.pe_busy) |=> lst_ff == LS_IGNORE)
    else $error("id read decoded while busy");
  AST_RSTEN_IGN: assert property (@(posedge sclk) disable iff (chip_select_n)
    s_opc_end and (op_c == `OP_RSTEN && cfg_s.wbusy) |=> !rst_arm_ff)
    else $error("reset enable accepted during register write");
  AST_WEL_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    ev_c && !wel_ff && (cmd_ff.op == `OP_WRNVCR || cmd_ff.op == `OP_WRVCR)
    |=> nvcr_ff == $past(nvcr_ff) && vcr_ff == $past(vcr_ff))
    else $error("nonvolatile write without write enable");
  AST_RST_ABORT: assert property (@(posedge clk) disable iff (!rst_n)
    sw_rst_c && pe_busy |=> pe_abort ##1 !pe_abort)
    else $error("reset did not abort operation for one cycle");
  AST_RST_VCR: assert property (@(posedge clk) disable iff (!rst_n)
    sw_rst_c |=> vcr_ff == vcr_from_nv(nvcr_ff) && addr4_ff == nvcr_ff[`NVCR_ADDR4])
    else $error("volatile config not restored by reset");
  AST_RST_READY: assert property (@(posedge clk) disable iff (!rst_n)
    sw_rst_c && !pe_busy |=> cfg_c.die_busy[0] ##[1:60] !cfg_c.die_busy[0])
    else $error("flag ready not reached after reset");

endmodule

// [fsr_host.sv]
// host side link model: frames on the flash pins, lane zero out
`timescale 1ns/1ps
`include "fsr_regs.svh"
module fsr_host (
  // link pins toward the flash
  output logic sclk,
  output logic chip_select_n,
  output logic [3:0] h_dq,
  // resolved lanes and device enables
  input wire logic [3:0] dq,
  input wire logic [3:0] oe_n
);
  logic drv; // device drove a lane during the read phase
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b0;
    h_dq = 4'ha;
    drv = 1'b0;
    // one clean rising select clears the device's frame state and outputs
    #1 chip_select_n = 1'b1;
  end
  // one bit on lane zero, changed while sclk is low
  task automatic put(input logic b);
    h_dq[0] = b;
    #40 sclk = 1'b1;
    #40 sclk = 1'b0;
  endtask
  // opcode, na address or write bits, nd dummies, nr bytes read
  task automatic frame(input logic [7:0] op, input int na, input logic [31:0] ad,
      input int nd, input int nr, output logic [63:0] rd);
    chip_select_n = 1'b0;
    drv = 1'b0;
    #40;
    for (int i = 7; i >= 0; i--) put(op[i]);
    for (int i = na - 1; i >= 0; i--) put(ad[i]);
    repeat (nd) put(~h_dq[0]);
    rd = '0;
    for (int i = 0; i < nr * 8; i++) begin
      #40 sclk = 1'b1;
      rd = {rd[62:0], dq[1]};
      drv = drv | (oe_n !== 4'hf);
      #40 sclk = 1'b0;
    end
    #40 chip_select_n = 1'b1;
    h_dq = ~h_dq;
    #1000;
  endtask
  // pair, gap, recovery; never in execute-in-place
  task automatic sw_reset();
    logic [63:0] r;
    frame(`OP_RSTEN, 0, '0, 0, 0, r);
    frame(`OP_RSTMEM, 0, '0, 0, 0, r);
    #6000;
  endtask
endmodule

// [serial_flash_reset_id_discovery_bench.sv]
// self-checking bench of the serial flash front end
`timescale 1ns/1ps
`include "fsr_regs.svh"
module serial_flash_reset_id_discovery_bench;
  localparam logic [31:0] ID_W = 32'h1234_5678; // arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b1;
  logic pe_busy = 1'b0;
  logic pe_suspended = 1'b0;
  logic tbl_wr_en = 1'b0;
  logic [10:0] tbl_wr_addr = '0;
  logic [7:0] tbl_wr_data = '0;
  logic sclk, chip_select_n, pe_abort, addr4_mode;
  logic [3:0] h_dq, dq_out, dq_oe_n, dq_in, dummy_cycles;
  logic [31:0] mem_addr;
  logic [7:0] mem_rdata;
  logic [7:0] tbl [2048]; // table image
  logic [63:0] rd;
  int failures = 0, cmp_count = 0, aborts = 0, cyc = 0;
  always #50 clk = ~clk;
  // wire level: device where enabled, host elsewhere
  assign dq_in = (dq_out & ~dq_oe_n) | (h_dq & dq_oe_n);
  // memory stand-in, byte derived from address
  function automatic logic [7:0] mb(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[31:24] ^ 8'h3c;
  endfunction
  assign mem_rdata = mb(mem_addr);
  function automatic logic [7:0] idb(input int n);
    return ID_W[8*(n%4) +: 8];
  endfunction
  fsr_top #(.ID_WORD(ID_W)) u_dut (.clk(clk), .rst_n(rst_n), .sclk(sclk),
    .chip_select_n(chip_select_n), .serial_data_lines_in(dq_in),
    .serial_data_lines_out(dq_out), .serial_data_lines_oe_n(dq_oe_n),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .pe_busy(pe_busy),
    .pe_suspended(pe_suspended), .pe_abort(pe_abort), .tbl_wr_en(tbl_wr_en),
    .tbl_wr_addr(tbl_wr_addr), .tbl_wr_data(tbl_wr_data),
    .addr4_mode(addr4_mode), .dummy_cycles(dummy_cycles));
  fsr_host u_host (.sclk(sclk), .chip_select_n(chip_select_n), .h_dq(h_dq),
    .dq(dq_in), .oe_n(dq_oe_n));
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  task automatic f(input logic [7:0] op, input int na, input logic [31:0] ad,
      input int nd, input int nr);
    u_host.frame(op, na, ad, nd, nr, rd);
  endtask
  // abort pulse count and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pe_abort === 1'b1) aborts <= aborts + 1;
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    int a, n, k;
    // a real falling edge also clears the link-clock hand-over flops
    rst_n <= 1'b0;
    a = $urandom(32'h4bf9f12e);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // random table load through the clk-side port
    for (int i = 0; i < 2048; i++) begin
      @(posedge clk);
      tbl[i] = 8'($urandom);
      tbl_wr_en <= 1'b1;
      tbl_wr_addr <= 11'(i);
      tbl_wr_data <= tbl[i];
    end
    @(posedge clk);
    tbl_wr_en <= 1'b0;
    #1000;
    // id bytes repeat every four; refused while busy
    f(`OP_RDID, 0, 0, 0, 5);
    chk("id", {idb(0), idb(1), idb(2), idb(3), idb(0)}, rd);
    chk("oe idle", 4'hf, dq_oe_n);
    @(posedge clk) pe_busy <= 1'b1;
    f(`OP_MIORDID, 0, 0, 0, 2);
    chk("id busy drive", 0, u_host.drv);
    @(posedge clk) pe_busy <= 1'b0;
    $display("test id done");
    // table read at the wrap point and at random
    f(`OP_SFDP, 24, 32'h7fe, 8, 4);
    chk("tbl wrap", {tbl[2046], tbl[2047], tbl[0], tbl[1]}, rd);
    a = $urandom % 2048;
    f(`OP_SFDP, 24, a, 8, 2);
    chk("tbl", {tbl[a], tbl[(a+1)%2048]}, rd);
    $display("test table done");
    // four-byte mode, linear read over both halves
    f(`OP_EN4B, 0, 0, 0, 0);
    chk("addr4", 1, addr4_mode);
    f(`OP_READ, 32, 32'h07ff_ffff, 0, 3);
    chk("mem", {mb(32'h07ff_ffff), mb(32'h0800_0000), mb(32'h0800_0001)}, rd);
    f(`OP_SFDP, 24, a, 8, 1);
    chk("tbl 4b", tbl[a], rd);
    f(`OP_RDFSR, 0, 0, 0, 1);
    chk("flag addr4", 1, rd[0]);
    f(`OP_RSTMEM, 0, 0, 0, 0);
    #6000;
    chk("lone 99", 1, addr4_mode);
    $display("test addr done");
    // volatile write ignored until write enable
    f(`OP_WRVCR, 8, 32'ha3, 0, 0);
    chk("dummy no wren", 8, dummy_cycles);
    f(`OP_WREN, 0, 0, 0, 0);
    f(`OP_WRVCR, 8, 32'ha3, 0, 0);
    chk("dummy", 4'ha, dummy_cycles);
    f(`OP_RDVCR, 0, 0, 0, 1);
    chk("vcr", 8'ha3, rd);
    // nonvolatile image, low byte first
    f(`OP_RDNVCR, 0, 0, 0, 2);
    chk("nvcr", 16'h0080, rd);
    // status write: reset refused, then per-die polling
    f(`OP_WREN, 0, 0, 0, 0);
    f(`OP_WRSR, 8, 32'h00, 0, 0);
    u_host.sw_reset();
    chk("rst refused", 1, addr4_mode);
    n = 0;
    k = 0;
    while (k < 2 && n < 60) begin
      f(`OP_RDSR, 0, 0, 0, 1);
      n++;
      k = (rd[0] === 1'b0) ? k + 1 : 0;
    end
    chk("poll busy", 1, n > 4);
    chk("poll done", 2, k);
    $display("test write done");
    // reset aborts a running, then a suspended operation
    for (int j = 0; j < 2; j++) begin
      f(`OP_EN4B, 0, 0, 0, 0);
      @(posedge clk);
      pe_busy <= (j == 0);
      pe_suspended <= (j == 1);
      // suspended: poll the flag before anything else
      if (j == 1) begin
        f(`OP_RDFSR, 0, 0, 0, 1);
        chk("suspend flag", 1, rd[7]);
      end
      u_host.sw_reset();
      chk("abort", j + 1, aborts);
      chk("addr4 rst", 0, addr4_mode);
      chk("dummy rst", 8, dummy_cycles);
      @(posedge clk);
      pe_busy <= 1'b0;
      pe_suspended <= 1'b0;
      f(`OP_RDFSR, 0, 0, 0, 1);
      chk("flag ready", 1, rd[7]);
    end
    $display("test reset done");
    report_and_stop();
  end
endmodule
